// file: wsm_pkg.sv
package wsm_pkg;

  // register byte offsets
  localparam logic [7:0] WSM_SENDER_OFS = 8'h00;
  localparam logic [7:0] WSM_GROUP_OFS = 8'h04;
  localparam logic [7:0] WSM_LIMIT_OFS = 8'h08;
  localparam logic [7:0] WSM_TIME_OFS = 8'h0c;
  localparam logic [7:0] WSM_STATUS_OFS = 8'h10;
  localparam logic [7:0] WSM_PLAUS_OFS = 8'h14;

  // reset values
  localparam logic [7:0] WSM_SENDER_RST = 8'h4d;
  localparam logic [7:0] WSM_GROUP_MAIN_RST = 8'h10;
  localparam logic [7:0] WSM_GROUP_SAFE_RST = 8'h11;
  localparam logic [15:0] WSM_ANGLE_LIM_RST = 16'h000f;
  localparam logic [15:0] WSM_SPEED_LIM_RST = 16'h0032;
  localparam logic [7:0] WSM_ANGLE_PERS_RST = 8'h0a;
  localparam logic [7:0] WSM_SPEED_PERS_RST = 8'h0a;
  localparam logic [7:0] WSM_TIMEOUT_RST = 8'h08;
  localparam logic [15:0] WSM_SPOOL_LIM_RST = 16'h0064;
  localparam logic [7:0] WSM_IDLE_LIM_RST = 8'h05;
  localparam logic [7:0] WSM_PLAUS_PERS_RST = 8'h0a;

  // status field positions
  localparam int WSM_ST_SAFE = 0;
  localparam int WSM_ST_TMO = 1;
  localparam int WSM_ST_SEQ = 3;
  localparam int WSM_ST_CRC = 5;
  localparam int WSM_ST_RNG = 7;
  localparam int WSM_ST_ADIV = 9;
  localparam int WSM_ST_SDIV = 10;
  localparam int WSM_ST_PLAUS = 11;

  // timing
  localparam int WSM_TICK_MS = 10;
  localparam int WSM_CLK_KHZ = 125000;
  localparam int WSM_TICK_CYC = WSM_TICK_MS * WSM_CLK_KHZ;
  localparam int WSM_STARTUP_S = 10;
  localparam int WSM_STARTUP_TICKS = WSM_STARTUP_S * 1000 / WSM_TICK_MS;

  // message value ranges and checksum
  localparam logic signed [15:0] WSM_ANGLE_MAX = 16'sh0708;
  localparam logic signed [15:0] WSM_SPEED_MAX = 16'sh03e8;
  localparam logic [7:0] WSM_CRC_POLY = 8'h1d;
  localparam logic [7:0] WSM_CRC_INIT = 8'hff;

  typedef struct packed {
    logic valid;
    logic [7:0] sender;
    logic [7:0] group;
    logic [3:0] seq;
    logic signed [15:0] angle;
    logic signed [15:0] speed;
    logic [7:0] crc;
  } wsm_frame_t;

  typedef struct packed {
    logic signed [15:0] wheel_angle;
    logic signed [15:0] spool_pos;
  } wsm_plaus_t;

endpackage

// file: wsm_monitor.sv
// Contract
// - main takes primary, safety takes redundant
// - filter by sender address, default 77
// - group offset filter, defaults 16 and 17
// - timeout, sequence, checksum and range checks applied to both channels
// - message timeout in ticks forces safe
// - sequence error forces safe state
// - checksum mismatch forces safe state
// - out-of-range value forces safe state
// - persistent angle divergence forces safe
// - persistent speed divergence forces safe
// - wheel, spool, steering plausibility forces safe
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
module wsm_monitor #(
  parameter int TICK_CYCLES = wsm_pkg::WSM_TICK_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire wsm_pkg::wsm_frame_t frame_main,
  input wire wsm_pkg::wsm_frame_t frame_safe,
  input wire wsm_pkg::wsm_plaus_t plaus,
  output logic safe_state
);
  import wsm_pkg::*;

  function automatic logic [7:0] crc8(input logic [35:0] d);
    logic [7:0] c;
    c = WSM_CRC_INIT;
    for (int i = 35; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ WSM_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  function automatic logic [15:0] absdiff(input logic signed [15:0] a,
                                          input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    if (d < 0) begin
      d = -d;
    end
    return (d > 17'sh0ffff) ? 16'hffff : d[15:0];
  endfunction

  // configuration registers
  logic [15:0] sender_r;
  logic [15:0] group_r;
  logic [31:0] limit_r;
  logic [23:0] time_r;
  logic [31:0] pcfg_r;
  // fault causes
  logic [1:0] tmo_f_r, seq_f_r, crc_f_r, rng_f_r;
  logic adiv_f_r, sdiv_f_r, plaus_f_r;
  logic [31:0] status;

  // bus slave
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rd_val;
  logic [7:0] a_ofs;
  logic acc;

  assign acc = hsel && htrans[1] && hready;
  assign a_ofs = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      // writes above the register window are dropped
      wr_pend_r <= acc && hwrite && haddr[31:8] == 24'h000000;
      wr_addr_r <= a_ofs;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[31:8] == 24'h000000) begin
      case (a_ofs)
        WSM_SENDER_OFS: rd_val = {16'h0000, sender_r};
        WSM_GROUP_OFS: rd_val = {16'h0000, group_r};
        WSM_LIMIT_OFS: rd_val = limit_r;
        WSM_TIME_OFS: rd_val = {8'h00, time_r};
        WSM_STATUS_OFS: rd_val = status;
        WSM_PLAUS_OFS: rd_val = pcfg_r;
        default: rd_val = 32'h0000_0000;
      endcase
    end
    // read right behind a write sees the new value
    if (wr_pend_r && wr_addr_r == a_ofs && a_ofs != WSM_STATUS_OFS &&
        haddr[31:8] == 24'h000000) begin
      case (a_ofs)
        WSM_SENDER_OFS: rd_val = {16'h0000, hwdata[15:0]};
        WSM_GROUP_OFS: rd_val = {16'h0000, hwdata[15:0]};
        WSM_TIME_OFS: rd_val = {8'h00, hwdata[23:0]};
        WSM_LIMIT_OFS: rd_val = hwdata;
        WSM_PLAUS_OFS: rd_val = hwdata;
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= rd_val;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sender_r <= {WSM_SENDER_RST, WSM_SENDER_RST};
      group_r <= {WSM_GROUP_SAFE_RST, WSM_GROUP_MAIN_RST};
      limit_r <= {WSM_SPEED_LIM_RST, WSM_ANGLE_LIM_RST};
      time_r <= {WSM_TIMEOUT_RST, WSM_SPEED_PERS_RST, WSM_ANGLE_PERS_RST};
      pcfg_r <= {WSM_PLAUS_PERS_RST, WSM_IDLE_LIM_RST, WSM_SPOOL_LIM_RST};
    end else if (wr_pend_r) begin
      case (wr_addr_r)
        WSM_SENDER_OFS: sender_r <= hwdata[15:0];
        WSM_GROUP_OFS: group_r <= hwdata[15:0];
        WSM_LIMIT_OFS: limit_r <= hwdata;
        WSM_TIME_OFS: time_r <= hwdata[23:0];
        WSM_PLAUS_OFS: pcfg_r <= hwdata;
        default: ;
      endcase
    end
  end

  // 10 ms tick
  logic [31:0] tick_cnt_r;
  logic tick;
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_r <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // per-channel checks, 0 = main/primary, 1 = safety/redundant
  wsm_frame_t frm [2];
  logic [1:0] seen_r;
  logic signed [15:0] ang_r [2];
  logic signed [15:0] spd_r [2];
  logic [1:0] tmo_ev, seq_ev, crc_ev, rng_ev;

  assign frm[0] = frame_main;
  assign frm[1] = frame_safe;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic hit;
    logic [3:0] last_seq_r;
    logic [15:0] tmo_cnt_r;
    logic [15:0] tmo_lim;

    // same sender value may serve both channels
    assign hit = frm[ch].valid &&
                 frm[ch].sender == sender_r[ch*8 +: 8] &&
                 frm[ch].group == group_r[ch*8 +: 8];
    assign tmo_lim = seen_r[ch] ? {8'h00, time_r[23:16]} :
                     16'(WSM_STARTUP_TICKS);

    assign seq_ev[ch] = hit && seen_r[ch] &&
                        frm[ch].seq != last_seq_r + 4'h1;
    assign crc_ev[ch] = hit && frm[ch].crc != crc8({frm[ch].seq,
                        frm[ch].angle, frm[ch].speed});
    assign rng_ev[ch] = hit &&
                        (frm[ch].angle > WSM_ANGLE_MAX ||
                         frm[ch].angle < -WSM_ANGLE_MAX ||
                         frm[ch].speed > WSM_SPEED_MAX ||
                         frm[ch].speed < -WSM_SPEED_MAX);
    assign tmo_ev[ch] = !hit && tick && tmo_cnt_r >= tmo_lim;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        seen_r[ch] <= 1'b0;
        last_seq_r <= 4'h0;
        ang_r[ch] <= 16'sh0000;
        spd_r[ch] <= 16'sh0000;
      end else if (hit) begin
        seen_r[ch] <= 1'b1;
        last_seq_r <= frm[ch].seq;
        ang_r[ch] <= frm[ch].angle;
        spd_r[ch] <= frm[ch].speed;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tmo_cnt_r <= 16'h0000;
      end else if (hit) begin
        tmo_cnt_r <= 16'h0000;
      end else if (tick && tmo_cnt_r != 16'hffff) begin
        tmo_cnt_r <= tmo_cnt_r + 16'h0001;
      end
    end
  end

  // channel cross-check
  logic [15:0] adiff, sdiff;
  logic [7:0] acnt_r, scnt_r;
  logic both;
  logic adiv_ev, sdiv_ev;

  assign both = &seen_r;
  assign adiff = absdiff(ang_r[0], ang_r[1]);
  assign sdiff = absdiff(spd_r[0], spd_r[1]);
  assign adiv_ev = tick && both && adiff > limit_r[15:0] &&
                   acnt_r >= time_r[7:0];
  assign sdiv_ev = tick && both && sdiff > limit_r[31:16] &&
                   scnt_r >= time_r[15:8];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acnt_r <= 8'h00;
    end else if (!both || adiff <= limit_r[15:0]) begin
      acnt_r <= 8'h00;
    end else if (tick && acnt_r != 8'hff) begin
      acnt_r <= acnt_r + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scnt_r <= 8'h00;
    end else if (!both || sdiff <= limit_r[31:16]) begin
      scnt_r <= 8'h00;
    end else if (tick && scnt_r != 8'hff) begin
      scnt_r <= scnt_r + 8'h01;
    end
  end

  // plausibility: spool and wheel movement against steering movement
  logic signed [15:0] wheel_prev_r;
  logic [15:0] spool_abs, wheel_step;
  logic [15:0] spd_abs;
  logic incons;
  logic [7:0] fcnt_r;
  logic plaus_ev;

  assign spool_abs = absdiff(plaus.spool_pos, 16'sh0000);
  assign wheel_step = absdiff(plaus.wheel_angle, wheel_prev_r);
  assign spd_abs = absdiff(spd_r[0], 16'sh0000);
  assign incons = both &&
                  ((spool_abs > pcfg_r[15:0] &&
                    spd_abs <= {8'h00, pcfg_r[23:16]}) ||
                   (wheel_step > {8'h00, pcfg_r[23:16]} &&
                    spool_abs <= pcfg_r[15:0] &&
                    spd_abs <= {8'h00, pcfg_r[23:16]}));
  // counters saturate so a long fault never wraps back
  assign plaus_ev = tick && incons && fcnt_r >= pcfg_r[31:24];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wheel_prev_r <= 16'sh0000;
    end else if (tick) begin
      wheel_prev_r <= plaus.wheel_angle;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcnt_r <= 8'h00;
    end else if (!incons) begin
      fcnt_r <= 8'h00;
    end else if (tick && fcnt_r != 8'hff) begin
      fcnt_r <= fcnt_r + 8'h01;
    end
  end

  // sticky causes and latched safe state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_f_r <= 2'b00;
      seq_f_r <= 2'b00;
      crc_f_r <= 2'b00;
      rng_f_r <= 2'b00;
      adiv_f_r <= 1'b0;
      sdiv_f_r <= 1'b0;
      plaus_f_r <= 1'b0;
    end else begin
      tmo_f_r <= tmo_f_r | tmo_ev;
      seq_f_r <= seq_f_r | seq_ev;
      crc_f_r <= crc_f_r | crc_ev;
      rng_f_r <= rng_f_r | rng_ev;
      adiv_f_r <= adiv_f_r | adiv_ev;
      sdiv_f_r <= sdiv_f_r | sdiv_ev;
      plaus_f_r <= plaus_f_r | plaus_ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safe_state <= 1'b0;
    end else if (|{tmo_ev, seq_ev, crc_ev, rng_ev, adiv_ev, sdiv_ev,
                   plaus_ev}) begin
      safe_state <= 1'b1;
    end else begin
      safe_state <= safe_state;
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[WSM_ST_SAFE] = safe_state;
    status[WSM_ST_TMO +: 2] = tmo_f_r;
    status[WSM_ST_SEQ +: 2] = seq_f_r;
    status[WSM_ST_CRC +: 2] = crc_f_r;
    status[WSM_ST_RNG +: 2] = rng_f_r;
    status[WSM_ST_ADIV] = adiv_f_r;
    status[WSM_ST_SDIV] = sdiv_f_r;
    status[WSM_ST_PLAUS] = plaus_f_r;
  end

endmodule

// file: wsm_sensor_node.sv
module wsm_sensor_node #(
  parameter logic [7:0] GROUP = 8'h10
) (
  input wire logic hclk,
  output wsm_pkg::wsm_frame_t frame
);
  timeunit 1ns;
  timeprecision 1ps;
  import wsm_pkg::*;
  logic [3:0] seq_r = 4'h0;
  initial frame = '0;
  function automatic logic [7:0] crc8(input logic [35:0] d);
    logic [7:0] c;
    c = WSM_CRC_INIT;
    for (int i = 35; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? WSM_CRC_POLY : 8'h00);
    end
    return c;
  endfunction
  // bad: 0 clean, 1 checksum flip, 2 sequence gap
  task automatic send(input logic signed [15:0] ang, spd, input int bad);
    wsm_frame_t f;
    f.valid = 1'b1;
    f.sender = WSM_SENDER_RST;
    f.group = GROUP;
    f.seq = seq_r + ((bad == 2) ? 4'h2 : 4'h1);
    f.angle = ang;
    f.speed = spd;
    f.crc = crc8({f.seq, ang, spd}) ^ {7'h0, bad == 1};
    frame <= f;
    seq_r <= f.seq;
    @(posedge hclk);
    f = ~f;
    f.valid = 1'b0;
    frame <= f;
    @(posedge hclk);
  endtask
endmodule

// file: wsm_monitor_assertions.sv
module wsm_monitor_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire wsm_pkg::wsm_frame_t frame_main,
  input wire wsm_pkg::wsm_frame_t frame_safe,
  input wire wsm_pkg::wsm_plaus_t plaus,
  input wire logic safe_state
);
  timeunit 1ns;
  timeprecision 1ps;
  import wsm_pkg::*;
  logic dflt_r;
  logic rd;
  logic acc;
  function automatic logic oor(input wsm_frame_t f);
    return f.angle > WSM_ANGLE_MAX || f.angle < -WSM_ANGLE_MAX ||
      f.speed > WSM_SPEED_MAX || f.speed < -WSM_SPEED_MAX;
  endfunction
  assign rd = hsel && htrans[1] && hready && !hwrite;
  assign acc = dflt_r && (frame_main.valid && oor(frame_main) &&
    frame_main.sender == WSM_SENDER_RST &&
    frame_main.group == WSM_GROUP_MAIN_RST || frame_safe.valid &&
    oor(frame_safe) && frame_safe.sender == WSM_SENDER_RST &&
    frame_safe.group == WSM_GROUP_SAFE_RST);
  // cleared once filter settings are rewritten
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dflt_r <= 1'b1;
    end else if (hsel && htrans[1] && hready && hwrite && haddr < 8) begin
      dflt_r <= 1'b0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  a_safe_latched: assert property (safe_state |=> safe_state)
    else $error("safe state dropped");
  a_range_safe: assert property (acc |=> safe_state)
    else $error("range fault missed");
  a_unmapped_zero: assert property (rd && haddr > 32'h14 |=> hrdata == 0)
    else $error("unmapped read not zero");
  a_status_safe: assert property (rd && haddr == 32'h10 |=>
    hrdata[WSM_ST_SAFE] == $past(safe_state))
    else $error("status safe bit wrong");
  a_sender_dflt: assert property (rd && dflt_r && haddr == 0 |=>
    hrdata[15:0] == {WSM_SENDER_RST, WSM_SENDER_RST})
    else $error("sender default wrong");
  a_group_dflt: assert property (rd && dflt_r && haddr == 4 |=>
    hrdata[15:0] == {WSM_GROUP_SAFE_RST, WSM_GROUP_MAIN_RST})
    else $error("group default wrong");
  a_limit_dflt: assert property (rd && haddr == 8 |=>
    hrdata == 32'h0032000f)
    else $error("limit default wrong");
  a_time_dflt: assert property (rd && haddr == 12 |=>
    hrdata == 32'h00080a0a)
    else $error("time default wrong");
endmodule
bind wsm_monitor wsm_monitor_checker i_chk (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
  .frame_main, .frame_safe, .plaus, .safe_state);

// file: test_dual_channel_wheel_sensor_monitor.sv
module test_dual_channel_wheel_sensor_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import wsm_pkg::*;
  localparam int TK = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic hreadyout;
  logic hresp;
  logic safe_state;
  logic [31:0] hrdata;
  logic [31:0] rd;
  wsm_plaus_t plaus = '0;
  wsm_frame_t fm;
  wsm_frame_t fs;
  int bad_count = 0;
  int cmp_count = 0;
  always #4 hclk = ~hclk;
  wsm_monitor #(.TICK_CYCLES(TK)) i_wsm_monitor (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .frame_main(fm), .frame_safe(fs), .plaus,
    .safe_state);
  wsm_sensor_node #(.GROUP(WSM_GROUP_MAIN_RST)) i_main (.hclk, .frame(fm));
  wsm_sensor_node #(.GROUP(WSM_GROUP_SAFE_RST)) i_safe (.hclk, .frame(fs));
  task automatic chk(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_rdy();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk("register", exp, rd);
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic tx(input int n, input logic signed [15:0] ma, ra, ms, rs);
    repeat (n) begin
      fork
        i_main.send(ma, ms, 0);
        i_safe.send(ra, rs, 0);
      join
    end
  endtask
  task automatic t_regs();
    rst();
    rd_chk(WSM_SENDER_OFS, 32'h00004d4d);
    rd_chk(WSM_GROUP_OFS, 32'h00001110);
    rd_chk(WSM_LIMIT_OFS, 32'h0032000f);
    rd_chk(WSM_TIME_OFS, 32'h00080a0a);
    rd_chk(WSM_PLAUS_OFS, 32'h0a050064);
    rd_chk(32'h40, 32'h0);
    bus(WSM_STATUS_OFS, 1'b1, 32'hffffffff);
    rd_chk(WSM_STATUS_OFS, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_faults();
    int fld [3] = '{WSM_ST_CRC, WSM_ST_SEQ, WSM_ST_RNG};
    for (int k = 0; k < 3; k++) begin
      rst();
      tx(3, 16'sh0708, 16'sh0708, -16'sh03e8, -16'sh03e8);
      chk("safe", 0, safe_state);
      if (k == 1) i_safe.send(0, 0, 2);
      else i_main.send((k == 2) ? 16'sh0709 : 16'sh0708, 0, k == 0);
      chk("safe", 1, safe_state);
      tx(3, 0, 0, 0, 0);
      bus(WSM_STATUS_OFS, 1'b0, 32'h0);
      chk("safe", 1, safe_state);
      chk("status", 1, {31'h0, |rd[fld[k] +: 2]});
    end
    $display("test faults done");
  endtask
  task automatic t_filter();
    rst();
    bus(WSM_GROUP_OFS, 1'b1, 32'h00001120);
    rd_chk(WSM_GROUP_OFS, 32'h00001120);
    i_main.send(0, 0, 1);
    chk("safe", 0, safe_state);
    $display("test filter done");
  endtask
  task automatic t_timeout();
    rst();
    tx(3, 0, 0, 0, 0);
    repeat (6 * TK) @(posedge hclk);
    chk("safe", 0, safe_state);
    repeat (4 * TK) @(posedge hclk);
    chk("safe", 1, safe_state);
    bus(WSM_STATUS_OFS, 1'b0, 32'h0);
    chk("timeout flags", 3, {30'h0, rd[WSM_ST_TMO +: 2]});
    $display("test timeout done");
  endtask
  task automatic t_div(input logic signed [15:0] da, ds, input string nm);
    rst();
    tx(50, 0, da + 1, 0, ds + 1);
    tx(30, 0, da, 0, ds);
    tx(80, 0, da + 1, 0, ds + 1);
    chk(nm, 0, safe_state);
    tx(140, 0, da + 1, 0, ds + 1);
    chk(nm, 1, safe_state);
    bus(WSM_STATUS_OFS, 1'b0, 32'h0);
    chk(nm, (ds != 0) ? 2 : 1, {30'h0, rd[WSM_ST_ADIV +: 2]});
    $display("test %s done", nm);
  endtask
  task automatic t_plaus();
    rst();
    plaus.spool_pos <= 16'sh0064;
    tx(80, 0, 0, 0, 0);
    chk("safe", 0, safe_state);
    plaus.spool_pos <= 16'sh0065;
    tx(140, 0, 0, 0, 0);
    chk("safe", 1, safe_state);
    bus(WSM_STATUS_OFS, 1'b0, 32'h0);
    chk("plausibility flag", 1, {31'h0, rd[WSM_ST_PLAUS]});
    plaus <= '0;
    $display("test plausibility done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    t_regs();
    t_faults();
    t_filter();
    t_timeout();
    t_div(15, 0, "angle divergence");
    t_div(0, 50, "speed divergence");
    t_plaus();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    tally_and_finish();
  end
endmodule
